// ==== inc/fub_pkg.sv ====
// Package: register map, field positions, reset values and types of the serial transceiver
package fub_pkg;
  // Register offsets (byte addresses on the peripheral register port)
  localparam logic [11:0] FUB_CTRL_OFS   = 12'h000;
  localparam logic [11:0] FUB_FLAGS_OFS  = 12'h004;
  localparam logic [11:0] FUB_DATA_OFS   = 12'h008;
  localparam logic [11:0] FUB_STEP_OFS   = 12'h00c;
  localparam logic [11:0] FUB_WRAP_OFS   = 12'h010;
  localparam logic [11:0] FUB_LEVEL_OFS  = 12'h014;
  // Control field positions
  localparam int FUB_TXE_BIT  = 0;
  localparam int FUB_RXE_BIT  = 1;
  localparam int FUB_PEN_BIT  = 2;
  localparam int FUB_EP_BIT   = 3;
  localparam int FUB_ST2_BIT  = 4;
  localparam int FUB_SB_BIT   = 5;
  localparam int FUB_OEN_BIT  = 7;
  localparam int FUB_XT_BIT   = 9;
  localparam int FUB_FCP_BIT  = 10;
  localparam int FUB_FCE_BIT  = 11;
  localparam int FUB_MRX_BIT  = 13;
  localparam int FUB_TST_BIT  = 14;
  localparam logic [15:0] FUB_CTRL_RST  = 16'h2080;
  localparam logic [15:0] FUB_CTRL_WMSK = 16'h7ebf;
  localparam logic [15:0] FUB_STEP_RST  = 16'h003f;
  localparam logic [15:0] FUB_WRAP_RST  = 16'h2710;
  localparam logic [4:0]  FUB_RXLVL_RST = 5'h01;
  localparam logic [4:0]  FUB_CTSLVL_RST = 5'h18;
  // Sizes and counts
  localparam int FUB_DATA_W   = 8;
  localparam int FUB_FIFO_D   = 32;
  localparam int FUB_BUF_D    = 16;
  localparam int FUB_IDLE_CHARS = 8;
  localparam logic [3:0] FUB_START_SAMPLES = 4'h7;
  localparam logic [3:0] FUB_BIT_END = 4'hf;
  localparam logic [3:0] FUB_MID16 = 4'h7;
  localparam logic [3:0] FUB_MID8  = 4'h3;
  localparam logic [3:0] FUB_END8  = 4'h7;
  localparam logic [3:0] FUB_CHAR_BITS = 4'hc;

  typedef struct packed {
    logic       brk;   // Frame was all zeros
    logic       fe;
    logic       pe;
    logic       se;
    logic [7:0] data;
  } fub_rxword_t;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } fub_busreq_t;
endpackage

// ==== hw/fub_fifo.sv ====
// Synchronous FIFO with valid/ready handshake on both sides
`timescale 1ns/1ps
`default_nettype none
module fub_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,     // Core clock
  input  wire logic         rstN,    // Synchronous reset, active low
  input  wire logic         flush,   // Empty the FIFO
  input  wire logic [W-1:0] inData,  // Write data
  input  wire logic         inValid, // Write request
  output var  logic         inReady, // Room available
  output var  logic [W-1:0] outData, // Head entry
  output var  logic         outValid,// Head valid
  input  wire logic         outReady,// Head taken
  output var  logic [$clog2(D):0] count // Fill level
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign inReady  = cnt_q != (AW+1)'(D);
  assign outValid = cnt_q != '0;
  assign outData  = mem[rp_q];
  assign count    = cnt_q;

  always_comb begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (flush) begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) wp_d = wp_q + AW'(1);
      if (pop) rp_d = rp_q + AW'(1);
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstN) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push && !flush) mem[wp_q] <= inData;
  end
endmodule
`default_nettype wire

// ==== hw/fub_uart.sv ====
// Serial transceiver: register port, fractional baud divider, transmitter, receiver, FIFOs
`timescale 1ns/1ps
`default_nettype none
module fub_uart (
  input  wire logic               core_clk,  // 50 MHz core clock
  input  wire logic               resetn,    // Synchronous reset, active low
  input  wire fub_pkg::fub_busreq_t busReq,  // Register access, one-cycle strobes
  output var  logic [31:0]        busRdata,  // Read data, valid cycle after rd
  output var  logic               busAck,    // Access done, one cycle after strobe
  input  wire logic               rxdPin,    // Serial receive pin
  input  wire logic               rtsPinN,   // Remote request input
  output var  logic               txdOut,    // Serial transmit output
  output var  logic               txdOe,     // Transmit pad enable
  output var  logic               ctsOutN,   // Clear-to-send, active low
  output var  logic               ctsOe,     // Clear-to-send pad enable
  output var  logic               rxIrq,     // Receiver ready interrupt
  output var  logic               txIrq      // Transmitter ready interrupt
);
  import fub_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} fub_txst_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_SHIFT} fub_rxst_t;

  // ---------------- Register state ----------------
  logic [15:0] ctrl_q, ctrl_d, step_q, step_d, wrap_q, wrap_d;
  logic [4:0]  rxLvl_q, rxLvl_d, ctsLvl_q, ctsLvl_d;
  logic [5:0]  flags_q, flags_d;   // rue roe toe fe pe se
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q;
  logic        wrCtrl, wrData, rdData, rdFlags, bothOff;
  logic [5:0]  fifoCnt [2];
  logic        txInReady, rxInReady, rxOutValid, txOutValid, txPop, rxPush;
  logic [7:0]  txHead;
  fub_rxword_t rxHead, rxWord;
  logic        rxRdyFlag, txRdyFlag;

  assign wrCtrl  = busReq.sel && busReq.wr;
  assign wrData  = wrCtrl && busReq.addr == FUB_DATA_OFS;
  assign rdData  = busReq.sel && busReq.rd && busReq.addr == FUB_DATA_OFS;
  assign rdFlags = busReq.sel && busReq.rd && busReq.addr == FUB_FLAGS_OFS;
  assign bothOff = !ctrl_q[FUB_TXE_BIT] && !ctrl_q[FUB_RXE_BIT];

  // ---------------- Baud divider ----------------
  logic [16:0] acc_q, acc_d;
  logic        sampleTick;
  always_comb begin
    acc_d      = acc_q + {1'b0, step_q} + 17'h1;
    sampleTick = 1'b0;
    if (acc_d >= {1'b0, wrap_q}) begin
      acc_d      = acc_d - {1'b0, wrap_q};
      sampleTick = 1'b1;
    end
    if (bothOff) begin
      acc_d      = '0;
      sampleTick = 1'b0;
    end
  end
  logic [3:0] bitEnd, bitMid;
  assign bitEnd = ctrl_q[FUB_XT_BIT] ? FUB_END8 : FUB_BIT_END;
  assign bitMid = ctrl_q[FUB_XT_BIT] ? FUB_MID8 : FUB_MID16;

  // ---------------- Input synchronisers and vote ----------------
  logic [1:0] rxSync_q, rtsSync_q;
  logic [2:0] vote_q;
  logic       rxVote, rxLine, rtsLevel;
  assign rxLine = ctrl_q[FUB_TST_BIT] ? txdOut : rxSync_q[1];
  assign rxVote = (vote_q[0] & vote_q[1]) | (vote_q[1] & vote_q[2]) | (vote_q[0] & vote_q[2]);
  assign rtsLevel = rtsSync_q[1];
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rxSync_q  <= 2'h3;
      rtsSync_q <= 2'h3;
      vote_q    <= 3'h7;
    end else begin
      rxSync_q  <= {rxSync_q[0], rxdPin};
      rtsSync_q <= {rtsSync_q[0], rtsPinN};
      vote_q    <= {vote_q[1:0], rxLine};
    end
  end

  // ---------------- FIFOs ----------------
  fub_fifo #(.W(FUB_DATA_W), .D(FUB_FIFO_D)) txFifo (
    .clk(core_clk), .rstN(resetn), .flush(bothOff),
    .inData(busReq.wdata[7:0]), .inValid(wrData && ctrl_q[FUB_TXE_BIT]), .inReady(txInReady),
    .outData(txHead), .outValid(txOutValid), .outReady(txPop), .count(fifoCnt[0]));
  fub_fifo #(.W($bits(fub_rxword_t)), .D(FUB_FIFO_D)) rxFifo (
    .clk(core_clk), .rstN(resetn), .flush(bothOff),
    .inData(rxWord), .inValid(rxPush), .inReady(rxInReady),
    .outData(rxHead), .outValid(rxOutValid), .outReady(rdData), .count(fifoCnt[1]));

  // ---------------- Transmitter ----------------
  fub_txst_t  txSt_q, txSt_d;
  logic [3:0] txTick_q, txTick_d, txBit_q, txBit_d;
  logic [11:0] txSh_q, txSh_d;
  logic       txd_q, txd_d, rtsStop;
  logic [3:0] txLast;
  assign rtsStop = ctrl_q[FUB_FCE_BIT] && (ctrl_q[FUB_FCP_BIT] ? !rtsLevel : rtsLevel);
  assign txLast  = 4'h9 + 4'(ctrl_q[FUB_PEN_BIT]) + 4'(ctrl_q[FUB_ST2_BIT]);
  assign txPop   = txSt_q == TX_IDLE && txOutValid && !rtsStop && ctrl_q[FUB_TXE_BIT]
                   && sampleTick;
  always_comb begin
    txSt_d   = txSt_q;
    txTick_d = txTick_q;
    txBit_d  = txBit_q;
    txSh_d   = txSh_q;
    unique case (txSt_q)
      TX_IDLE: begin
        if (txPop) begin
          // Stop, stop, parity/stop, data LSB first, start
          txSh_d   = {2'b11, ctrl_q[FUB_PEN_BIT] ? (^txHead ^ !ctrl_q[FUB_EP_BIT]) : 1'b1,
                      txHead, 1'b0};
          txTick_d = '0;
          txBit_d  = '0;
          txSt_d   = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (sampleTick) begin
          txTick_d = txTick_q + 4'h1;
          if (txTick_q == bitEnd) begin
            txTick_d = '0;
            txSh_d   = {1'b1, txSh_q[11:1]};
            txBit_d  = txBit_q + 4'h1;
            if (txBit_q == txLast) txSt_d = TX_IDLE;
          end
        end
      end
    endcase
    if (!ctrl_q[FUB_TXE_BIT]) txSt_d = TX_IDLE;
    txd_d = ctrl_q[FUB_SB_BIT] ? 1'b0 : (txSt_d == TX_SHIFT ? txSh_d[0] : 1'b1);
  end

  // ---------------- Receiver ----------------
  fub_rxst_t  rxSt_q, rxSt_d;
  logic [3:0] rxTick_q, rxTick_d, rxBit_q, rxBit_d, idleCnt_q, idleCnt_d;
  logic [10:0] rxSh_q, rxSh_d;
  logic       prev_q, prev_d, armed_q, armed_d, allZero_q, allZero_d;
  logic [3:0] rxLast;
  logic       parErr, stopBit;
  assign rxLast  = 4'h9 + 4'(ctrl_q[FUB_PEN_BIT]);
  assign stopBit = rxVote;
  assign parErr  = ctrl_q[FUB_PEN_BIT] && ((^rxSh_q[10:2]) != !ctrl_q[FUB_EP_BIT]);
  // With parity the data sits one place lower in the shift register
  logic [7:0] rxDataAligned;
  assign rxDataAligned = ctrl_q[FUB_PEN_BIT] ? rxSh_q[9:2] : rxSh_q[10:3];
  always_comb begin
    rxSt_d    = rxSt_q;
    rxTick_d  = rxTick_q;
    rxBit_d   = rxBit_q;
    rxSh_d    = rxSh_q;
    prev_d    = prev_q;
    armed_d   = armed_q;
    allZero_d = allZero_q;
    rxPush    = 1'b0;
    rxWord    = '0;
    if (sampleTick) begin
      prev_d = rxVote;
      unique case (rxSt_q)
        RX_IDLE: begin
          if (rxVote) begin
            rxTick_d = (rxTick_q == bitEnd) ? rxTick_q : rxTick_q + 4'h1;
            if (rxTick_q == bitEnd) armed_d = 1'b1;
          end else if (prev_q && armed_q && ctrl_q[FUB_RXE_BIT]) begin
            rxSt_d   = RX_START;
            rxTick_d = '0;
          end else begin
            rxTick_d = '0;
          end
        end
        RX_START: begin
          rxTick_d = rxTick_q + 4'h1;
          if (rxVote && rxTick_q < FUB_START_SAMPLES - 4'h1) begin
            rxSt_d   = RX_IDLE;  // glitch rejected
            rxTick_d = '0;
            armed_d  = 1'b0;
          end else if (rxTick_q == bitEnd) begin
            rxSt_d    = RX_SHIFT;
            rxTick_d  = '0;
            rxBit_d   = 4'h1;
            allZero_d = 1'b1;
          end
        end
        RX_SHIFT: begin
          rxTick_d = rxTick_q + 4'h1;
          if (rxTick_q == bitMid) begin
            rxSh_d = {rxVote, rxSh_q[10:1]};
            if (rxVote) allZero_d = 1'b0;
            if (rxBit_q == rxLast) begin
              rxPush        = rxInReady;
              rxWord.brk    = allZero_q && !stopBit;
              rxWord.fe     = !stopBit;
              rxWord.pe     = parErr;
              rxWord.data   = rxDataAligned;
              rxSt_d  = RX_IDLE;
              armed_d = stopBit;
              rxTick_d = '0;
            end
          end else if (rxTick_q == bitEnd) begin
            rxTick_d = '0;
            rxBit_d  = rxBit_q + 4'h1;
          end
        end
        default: rxSt_d = RX_IDLE;
      endcase
    end
  end
  // ---------------- Idle timeout ----------------
  logic [7:0] idleTick_q, idleTick_d;
  logic       timeout_q, timeout_d;
  always_comb begin
    idleTick_d = idleTick_q;
    idleCnt_d  = idleCnt_q;
    timeout_d  = timeout_q && rxOutValid;
    if (rxPush || !rxOutValid || rxSt_q != RX_IDLE) begin
      idleTick_d = '0;
      idleCnt_d  = '0;
      timeout_d  = 1'b0;
    end else if (sampleTick) begin
      idleTick_d = idleTick_q + 8'h1;
      if (idleTick_q[7:4] == FUB_CHAR_BITS - 4'h1 && idleTick_q[3:0] == bitEnd) begin
        idleTick_d = '0;
        idleCnt_d  = idleCnt_q + 4'h1;
        if (idleCnt_q == 4'(FUB_IDLE_CHARS - 1)) timeout_d = 1'b1;
      end
    end
  end

  // ---------------- Registers and flags ----------------
  assign rxRdyFlag = (fifoCnt[1] >= {1'b0, rxLvl_q} && rxOutValid) || timeout_q;
  assign txRdyFlag = fifoCnt[0] < 6'h8;
  always_comb begin
    ctrl_d   = ctrl_q;
    step_d   = step_q;
    wrap_d   = wrap_q;
    rxLvl_d  = rxLvl_q;
    ctsLvl_d = ctsLvl_q;
    flags_d  = flags_q;
    rdata_d  = '0;
    if (wrCtrl) begin
      unique case (busReq.addr)
        FUB_CTRL_OFS:  ctrl_d = busReq.wdata[15:0] & FUB_CTRL_WMSK;
        FUB_STEP_OFS:  step_d = busReq.wdata[15:0];
        FUB_WRAP_OFS:  wrap_d = busReq.wdata[15:0];
        FUB_LEVEL_OFS: begin
          rxLvl_d  = busReq.wdata[4:0];
          ctsLvl_d = busReq.wdata[12:8];
        end
        default: ;
      endcase
    end
    if (busReq.sel && busReq.rd) begin
      unique case (busReq.addr)
        FUB_CTRL_OFS:  rdata_d = {16'h0, ctrl_q};
        FUB_FLAGS_OFS: rdata_d = {24'h0, txRdyFlag, rxRdyFlag, flags_q};
        FUB_DATA_OFS:  rdata_d = {20'h0, rxHead.brk, rxHead.fe, rxHead.pe, rxHead.se, rxHead.data};
        FUB_STEP_OFS:  rdata_d = {16'h0, step_q};
        FUB_WRAP_OFS:  rdata_d = {16'h0, wrap_q};
        FUB_LEVEL_OFS: rdata_d = {19'h0, ctsLvl_q, 3'h0, rxLvl_q};
        default:       rdata_d = '0;
      endcase
    end
    if (rdFlags) flags_d = '0;
    if (rdData && rxOutValid) flags_d[2:0] = {rxHead.fe, rxHead.pe, rxHead.se};
    // Hardware sets win over the read-clear
    if (rdData && !rxOutValid) flags_d[5] = 1'b1;
    if (rxSt_q == RX_SHIFT && sampleTick && rxTick_q == bitMid && rxBit_q == rxLast && !rxInReady)
      flags_d[4] = 1'b1;
    if (wrData && ctrl_q[FUB_TXE_BIT] && !txInReady) flags_d[3] = 1'b1;
    if (bothOff) flags_d = '0;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q     <= FUB_CTRL_RST;
      step_q     <= FUB_STEP_RST;
      wrap_q     <= FUB_WRAP_RST;
      rxLvl_q    <= FUB_RXLVL_RST;
      ctsLvl_q   <= FUB_CTSLVL_RST;
      flags_q    <= '0;
      rdata_q    <= '0;
      ack_q      <= 1'b0;
      acc_q      <= '0;
      txSt_q     <= TX_IDLE;
      txTick_q   <= '0;
      txBit_q    <= '0;
      txSh_q     <= '1;
      txd_q      <= 1'b1;
      rxSt_q     <= RX_IDLE;
      rxTick_q   <= '0;
      rxBit_q    <= '0;
      rxSh_q     <= '0;
      prev_q     <= 1'b1;
      armed_q    <= 1'b0;
      allZero_q  <= 1'b0;
      idleTick_q <= '0;
      idleCnt_q  <= '0;
      timeout_q  <= 1'b0;
      rxIrq      <= 1'b0;
      txIrq      <= 1'b0;
      ctsOutN    <= 1'b1;
      txdOe      <= 1'b0;
      ctsOe      <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      step_q     <= step_d;
      wrap_q     <= wrap_d;
      rxLvl_q    <= rxLvl_d;
      ctsLvl_q   <= ctsLvl_d;
      flags_q    <= flags_d;
      rdata_q    <= rdata_d;
      ack_q      <= busReq.sel && (busReq.rd || busReq.wr);
      acc_q      <= acc_d;
      txSt_q     <= txSt_d;
      txTick_q   <= txTick_d;
      txBit_q    <= txBit_d;
      txSh_q     <= txSh_d;
      txd_q      <= txd_d;
      rxSt_q     <= rxSt_d;
      rxTick_q   <= rxTick_d;
      rxBit_q    <= rxBit_d;
      rxSh_q     <= rxSh_d;
      prev_q     <= prev_d;
      armed_q    <= armed_d && ctrl_q[FUB_RXE_BIT];
      allZero_q  <= allZero_d;
      idleTick_q <= idleTick_d;
      idleCnt_q  <= idleCnt_d;
      timeout_q  <= timeout_d;
      rxIrq      <= rxRdyFlag && !ctrl_q[FUB_MRX_BIT];
      txIrq      <= txRdyFlag && ctrl_q[FUB_TXE_BIT] && !ctrl_q[FUB_MRX_BIT - 1];
      // Low means ready to accept; high when fill reaches the watermark
      ctsOutN    <= ctrl_q[FUB_FCE_BIT] ? (fifoCnt[1] >= {1'b0, ctsLvl_q}) : 1'b0;
      txdOe      <= !ctrl_q[FUB_OEN_BIT];
      ctsOe      <= !ctrl_q[FUB_OEN_BIT];
    end
  end
  assign txdOut   = txd_q;
  assign busRdata = rdata_q;
  assign busAck   = ack_q;

  // ---------------- Assertions ----------------
  a_tx_idle_high: assert property (@(posedge core_clk) disable iff (!resetn)
    (txSt_q == TX_IDLE && !ctrl_q[FUB_SB_BIT] && !txPop) |=> txdOut)
    else $error("transmit line not idle high");
  a_tx_start_low: assert property (@(posedge core_clk) disable iff (!resetn)
    (txPop && !ctrl_q[FUB_SB_BIT]) |=> !txdOut)
    else $error("start bit not low");
  a_flow_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    rtsStop |-> !txPop)
    else $error("character started while flow stopped");
  a_flow_off_go: assert property (@(posedge core_clk) disable iff (!resetn)
    (txSt_q == TX_IDLE && txOutValid && !ctrl_q[FUB_FCE_BIT] && ctrl_q[FUB_TXE_BIT] && sampleTick) |-> txPop)
    else $error("transmit held without flow control");
  a_flush_both: assert property (@(posedge core_clk) disable iff (!resetn)
    bothOff |=> (fifoCnt[0] == 6'h0 && fifoCnt[1] == 6'h0 && flags_q == 6'h0))
    else $error("FIFOs not flushed");
  a_overrun_keep: assert property (@(posedge core_clk) disable iff (!resetn)
    (!rxInReady && !rdData && !bothOff) |=> fifoCnt[1] == 6'(FUB_FIFO_D))
    else $error("full receive FIFO changed");
  a_vote_major: assert property (@(posedge core_clk) disable iff (!resetn)
    (vote_q == 3'b101) |-> rxVote)
    else $error("majority vote wrong");
  a_cts_water: assert property (@(posedge core_clk) disable iff (!resetn)
    (ctrl_q[FUB_FCE_BIT] && $stable(ctrl_q)) |=> ctsOutN == ($past(fifoCnt[1]) >= {1'b0, $past(ctsLvl_q)}))
    else $error("clear-to-send wrong");
  a_rx_irq_mask: assert property (@(posedge core_clk) disable iff (!resetn)
    ctrl_q[FUB_MRX_BIT] |=> !rxIrq)
    else $error("masked ready interrupt posted");
  a_baud_tick: assert property (@(posedge core_clk) disable iff (!resetn)
    acc_q < {1'b0, wrap_q} || $changed(wrap_q))
    else $error("divider accumulator out of range");
  c_tx_char: cover property (@(posedge core_clk) disable iff (!resetn) txPop);
  c_rx_char: cover property (@(posedge core_clk) disable iff (!resetn) rxPush);
  c_rx_break: cover property (@(posedge core_clk) disable iff (!resetn) rxPush && rxWord.brk);
  c_timeout: cover property (@(posedge core_clk) disable iff (!resetn) $rose(timeout_q));
endmodule
`default_nettype wire

// ==== verification/fub_remote.sv ====
// Remote serial device model: frame sender, frame catcher, request line
`timescale 1ns/1ps
`default_nettype none
module fub_remote #(
  parameter int BITCLKS = 16
) (
  input  wire logic core_clk, // Core clock
  input  wire logic txdIn,    // Line from the device
  output var  logic rxdOut,   // Line to the device, idles high
  output var  logic rtsOutN   // Request line to the device
);
  initial begin
    rxdOut = 1'b1;
    rtsOutN = 1'b0;
  end
  task automatic setRts(input logic v);
    @(posedge core_clk) #1 rtsOutN = v;
  endtask
  // Start low, data LSB first, caller picks stop level
  task automatic sendFrame(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge core_clk) #1 rxdOut = (i < 10) ? f[i] : 1'b1;
      repeat (BITCLKS - 1) @(posedge core_clk);
    end
  endtask
  // Waits for a start, samples each bit mid-cell
  task automatic getFrame(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    while (txdIn !== 1'b0 && n < 4000) begin
      @(posedge core_clk) #1;
      n++;
    end
    ok = (n < 4000);
    repeat (BITCLKS / 2) @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BITCLKS) @(posedge core_clk);
      #1;
      if (i < 8) d[i] = txdIn;
      else if (txdIn !== 1'b1) ok = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== verification/fub_uart_bench.sv ====
// Bench for the serial transceiver: register accesses against a remote device model
`timescale 1ns/1ps
`default_nettype none
module fub_uart_bench;
  import fub_pkg::*;
  logic        core_clk;
  logic        resetn;
  fub_busreq_t busReq;
  logic [31:0] busRdata;
  logic        busAck;
  logic        rxdPin;
  logic        rtsPinN;
  logic        txdOut;
  logic        txdOe;
  logic        ctsOutN;
  logic        ctsOe;
  logic        rxIrq;
  logic        txIrq;
  int          failures;
  int          samples_checked;
  int          cycles;
  fub_uart i_fub_uart (.core_clk(core_clk), .resetn(resetn), .busReq(busReq), .busRdata(busRdata),
    .busAck(busAck), .rxdPin(rxdPin), .rtsPinN(rtsPinN), .txdOut(txdOut), .txdOe(txdOe),
    .ctsOutN(ctsOutN), .ctsOe(ctsOe), .rxIrq(rxIrq), .txIrq(txIrq));
  fub_remote i_fub_remote (.core_clk(core_clk), .txdIn(txdOut), .rxdOut(rxdPin), .rtsOutN(rtsPinN));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic wrap_up;
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle strobe; answer and acknowledge land one cycle later
  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk) #1;
    busReq = '{sel: 1'b1, wr: wr, rd: !wr, addr: a, wdata: wd};
    @(posedge core_clk) #1;
    busReq = '0;
    rd = busRdata;
    chk({31'h0, busAck}, 32'h1);
  endtask
  task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    access(1'b1, a, d, x);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    access(1'b0, a, 32'h0, x);
    chk(x & m, e);
  endtask
  task automatic txChk(input logic [7:0] e);
    logic [7:0] b;
    logic       ok;
    i_fub_remote.getFrame(b, ok);
    chk({23'h0, ok, b}, {24'h1, e});
  endtask
  initial begin
    logic held;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    resetn = 1'b0;
    busReq = '0;
    repeat (5) @(posedge core_clk);
    #1 resetn = 1'b1;
    chk({29'h0, txdOut, ctsOutN, txdOe}, 32'h6);
    rdChk(FUB_CTRL_OFS, '1, {16'h0, FUB_CTRL_RST});
    rdChk(FUB_STEP_OFS, '1, 32'h3f);
    rdChk(FUB_WRAP_OFS, '1, 32'h2710);
    rdChk(FUB_LEVEL_OFS, '1, 32'h1801);
    rdChk(12'h020, '1, 32'h0);
    // Tick every clock: a bit is sixteen clocks
    wrReg(FUB_STEP_OFS, 32'hf);
    wrReg(FUB_WRAP_OFS, 32'h10);
    wrReg(FUB_CTRL_OFS, 32'h4003);
    repeat (40) @(posedge core_clk);
    chk({29'h0, ctsOe, ctsOutN, txIrq}, 32'h5);
    wrReg(FUB_DATA_OFS, 32'ha5);
    repeat (250) @(posedge core_clk);
    rdChk(FUB_DATA_OFS, '1, 32'ha5);
    // Loop-back with even parity, two stop bits and 8x oversampling
    wrReg(FUB_CTRL_OFS, 32'h421f);
    wrReg(FUB_DATA_OFS, 32'h31);
    repeat (150) @(posedge core_clk);
    rdChk(FUB_DATA_OFS, '1, 32'h31);
    // Fill the receive FIFO past its depth: the two late characters are dropped
    for (int k = 0; k < 34; k++) begin
      wrReg(FUB_DATA_OFS, 32'(k));
      repeat (100) @(posedge core_clk);
    end
    rdChk(FUB_FLAGS_OFS, 32'h10, 32'h10);
    for (int k = 0; k < 32; k++) rdChk(FUB_DATA_OFS, '1, 32'(k));
    rdChk(FUB_FLAGS_OFS, 32'h40, 32'h0);
    wrReg(FUB_CTRL_OFS, 32'h0003);
    repeat (40) @(posedge core_clk);
    wrReg(FUB_DATA_OFS, 32'h3c);
    txChk(8'h3c);
    wrReg(FUB_CTRL_OFS, 32'h0023);
    @(posedge core_clk) #1;
    chk({31'h0, txdOut}, 32'h0);
    wrReg(FUB_CTRL_OFS, 32'h0003);
    i_fub_remote.sendFrame(8'h96, 1'b1);
    rdChk(FUB_DATA_OFS, '1, 32'h96);
    i_fub_remote.sendFrame(8'h00, 1'b0);
    repeat (40) @(posedge core_clk);
    rdChk(FUB_DATA_OFS, '1, 32'hc00);
    i_fub_remote.setRts(1'b1);
    wrReg(FUB_DATA_OFS, 32'h11);
    txChk(8'h11);
    wrReg(FUB_CTRL_OFS, 32'h0803);
    wrReg(FUB_DATA_OFS, 32'h5a);
    held = 1'b1;
    repeat (200) @(posedge core_clk) held &= txdOut;
    chk({31'h0, held}, 32'h1);
    i_fub_remote.setRts(1'b0);
    txChk(8'h5a);
    wrReg(FUB_CTRL_OFS, 32'h0003);
    repeat (40) @(posedge core_clk);
    i_fub_remote.sendFrame(8'h77, 1'b1);
    rdChk(FUB_FLAGS_OFS, 32'h40, 32'h40);
    chk({31'h0, rxIrq}, 32'h1);
    wrReg(FUB_CTRL_OFS, 32'h0000);
    repeat (4) @(posedge core_clk);
    rdChk(FUB_FLAGS_OFS, 32'h40, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
